// file: hw/ddr_ca_pkg.sv
// Shared constants and types for the command/address pin interface
package ddr_ca_pkg;
  localparam int ROW_W = 16;
  localparam int BANK_W = 3;
  localparam int DQ_W = 8;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int MR_SEL_W = 2;
  localparam int NUM_BANKS = 8;
  // Command code {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DES = 4'h8;
  // Mode register bits used here
  localparam int MR0_BL_LO = 0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam int MR1_RTT_A = 2;
  localparam int MR1_RTT_B = 6;
  localparam int MR1_RTT_C = 9;
  localparam int MR1_TDQS = 11;
  localparam logic [1:0] MR_IDX0 = 2'h0;
  localparam logic [1:0] MR_IDX1 = 2'h1;
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_PDN_ACT = 2'b01,
    PWR_PDN_PRE = 2'b11,
    PWR_SELF_REF = 2'b10
  } pwr_state_t;
endpackage : ddr_ca_pkg

// file: hw/ddr_ca_if.sv
// Pin-level interface between controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface ddr_ca_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [ddr_ca_pkg::BANK_W-1:0] ba;
  logic [ddr_ca_pkg::ROW_W-1:0] addr;
  logic odt;
  logic reset_n;
  logic dm;
  logic [ddr_ca_pkg::DQ_W-1:0] dq_wr;
  logic dq_wr_valid;
  modport ctrl (
    output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, reset_n,
    output dm, dq_wr, dq_wr_valid
  );
  modport dev (
    input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, reset_n,
    input dm, dq_wr, dq_wr_valid
  );
endinterface : ddr_ca_if
`default_nettype wire

// file: hw/ddr_ca_ctrl.sv
// Controller end: drives commands and write data onto the pins
`timescale 1ns/1ps
`default_nettype none
module ddr_ca_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // User command request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_cmd,
  input wire logic [ddr_ca_pkg::BANK_W-1:0] req_bank,
  input wire logic [ddr_ca_pkg::ROW_W-1:0] req_addr,
  input wire logic req_cke,
  input wire logic req_odt,
  input wire logic mem_reset_n,
  // User write data
  input wire logic wr_valid,
  input wire logic [ddr_ca_pkg::DQ_W-1:0] wr_data,
  input wire logic wr_mask,
  // Pins
  ddr_ca_if.ctrl pins
);
  // Commands are accepted every cycle; one cycle later on the pins
  assign req_ready = 1'b1;

  // ----------------------------------------------------------------
  // Command, address and control pins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= ddr_ca_pkg::CMD_DES;
      pins.ba <= '0;
      pins.addr <= '0;
    end else if (req_valid) begin
      // Chip select is the top of the command code
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= req_cmd;
      pins.ba <= req_bank;
      pins.addr <= req_addr;
    end else begin
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= ddr_ca_pkg::CMD_DES;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.cke <= 1'b0;
      pins.odt <= 1'b0;
    end else begin
      pins.cke <= req_cke;
      pins.odt <= req_odt;
    end
  end

  // Reset pin is the user level ANDed with the controller reset rst_n
  assign pins.reset_n = mem_reset_n & rst_n;

  // ----------------------------------------------------------------
  // Write data and mask
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.dq_wr <= '0;
      pins.dm <= 1'b0;
      pins.dq_wr_valid <= 1'b0;
    end else begin
      pins.dq_wr <= wr_data;
      pins.dm <= wr_mask;
      pins.dq_wr_valid <= wr_valid;
    end
  end
endmodule : ddr_ca_ctrl
`default_nettype wire

// file: hw/ddr_ca_dev.sv
// Device end: samples and decodes command, address and control pins
//
// Function
// - Address carries row, column, auto-precharge on A10
// - Precharge A10 low one bank, high all
// - Mode load carries op-code on address
// - OTF chop: A12 high eight, low four
// - Bank address picks target bank
// - Bank address picks mode register zero-three
// - Inputs sampled on rising clock crossing
// - Clock enable low gives power-down or self-refresh
// - CKE synchronous except self-refresh exit (here that exit is also sampled on the rising clock)
// - Input buffers gated in power-down, self-refresh (here the ODT buffer is gated in self-refresh only)
// - Chip select high masks every command
// - Strobes plus chip select form command
// - Masked write beats are discarded
// - Byte-wide mask ball may become termination strobe
// - Termination input enables termination on data balls
// - Termination input ignored when disabled by mode
// - Reset active low, asynchronous both ways
`timescale 1ns/1ps
`default_nettype none
module ddr_ca_dev #(
  parameter int ROW_W = ddr_ca_pkg::ROW_W,
  parameter int COL_W = 10
) (
  // Clock and pins
  input wire logic ref_clk,
  ddr_ca_if.dev pins,
  // Decoded command strobes
  output logic act_pulse,
  output logic rd_pulse,
  output logic wr_pulse,
  output logic pre_pulse,
  output logic ref_pulse,
  output logic mrs_pulse,
  // Decoded fields
  output logic [ddr_ca_pkg::BANK_W-1:0] cmd_bank,
  output logic [ROW_W-1:0] row_addr,
  output logic [COL_W-1:0] col_addr,
  output logic auto_pre,
  output logic pre_all,
  output logic burst_four,
  output logic [ROW_W-1:0] mode_reg [4],
  // Power and termination state
  output var ddr_ca_pkg::pwr_state_t pwr_state,
  output logic term_on,
  output logic tdqs_on,
  output logic [ddr_ca_pkg::NUM_BANKS-1:0] bank_open,
  // Accepted write data
  output logic wr_beat_valid,
  output logic [ddr_ca_pkg::DQ_W-1:0] wr_beat_data
);
  logic rst_n;
  logic [3:0] cmd;
  logic cke_q;
  logic ca_buf_on;
  logic odt_buf_on;
  logic otf_en;
  logic term_allowed;
  logic [ddr_ca_pkg::NUM_BANKS-1:0] next_bank_open;

  // Reset acts on the pin itself, without the clock
  assign rst_n = pins.reset_n;

  // Input buffer gating by power state
  assign ca_buf_on = (pwr_state == ddr_ca_pkg::PWR_ACTIVE);
  assign odt_buf_on = (pwr_state != ddr_ca_pkg::PWR_SELF_REF);

  // Deselected or gated inputs decode as a no-op
  assign cmd = (ca_buf_on && cke_q && pins.cke)
    ? {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n}
    : ddr_ca_pkg::CMD_DES;

  assign otf_en = (mode_reg[ddr_ca_pkg::MR_IDX0][ddr_ca_pkg::MR0_BL_LO +: 2]
    == ddr_ca_pkg::BL_OTF);
  assign term_allowed =
    mode_reg[ddr_ca_pkg::MR_IDX1][ddr_ca_pkg::MR1_RTT_A] |
    mode_reg[ddr_ca_pkg::MR_IDX1][ddr_ca_pkg::MR1_RTT_B] |
    mode_reg[ddr_ca_pkg::MR_IDX1][ddr_ca_pkg::MR1_RTT_C];
  assign tdqs_on =
    mode_reg[ddr_ca_pkg::MR_IDX1][ddr_ca_pkg::MR1_TDQS];

  // ----------------------------------------------------------------
  // Command decode, sampled on the rising crossing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      wr_pulse <= 1'b0;
      pre_pulse <= 1'b0;
      ref_pulse <= 1'b0;
      mrs_pulse <= 1'b0;
    end else begin
      act_pulse <= (cmd == ddr_ca_pkg::CMD_ACT);
      rd_pulse <= (cmd == ddr_ca_pkg::CMD_RD);
      wr_pulse <= (cmd == ddr_ca_pkg::CMD_WR);
      pre_pulse <= (cmd == ddr_ca_pkg::CMD_PRE);
      ref_pulse <= (cmd == ddr_ca_pkg::CMD_REF);
      mrs_pulse <= (cmd == ddr_ca_pkg::CMD_MRS);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_bank <= '0;
      row_addr <= '0;
      col_addr <= '0;
      auto_pre <= 1'b0;
      pre_all <= 1'b0;
      burst_four <= 1'b0;
    end else begin
      case (cmd)
        ddr_ca_pkg::CMD_ACT: begin
          cmd_bank <= pins.ba;
          row_addr <= pins.addr[ROW_W-1:0];
        end
        ddr_ca_pkg::CMD_RD, ddr_ca_pkg::CMD_WR: begin
          cmd_bank <= pins.ba;
          col_addr <= pins.addr[COL_W-1:0];
          auto_pre <= pins.addr[ddr_ca_pkg::AP_BIT];
          burst_four <= otf_en & ~pins.addr[ddr_ca_pkg::BC_BIT];
        end
        ddr_ca_pkg::CMD_PRE: begin
          cmd_bank <= pins.ba;
          pre_all <= pins.addr[ddr_ca_pkg::AP_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < $size(mode_reg); i++) begin
        mode_reg[i] <= '0;
      end
    end else if (cmd == ddr_ca_pkg::CMD_MRS) begin
      mode_reg[pins.ba[ddr_ca_pkg::MR_SEL_W-1:0]] <=
        pins.addr[ROW_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Open-row tracking
  // ----------------------------------------------------------------
  always_comb begin
    next_bank_open = bank_open;
    case (cmd)
      ddr_ca_pkg::CMD_ACT: next_bank_open[pins.ba] = 1'b1;
      ddr_ca_pkg::CMD_PRE: begin
        if (pins.addr[ddr_ca_pkg::AP_BIT]) begin
          next_bank_open = '0;
        end else begin
          next_bank_open[pins.ba] = 1'b0;
        end
      end
      ddr_ca_pkg::CMD_RD, ddr_ca_pkg::CMD_WR: begin
        if (pins.addr[ddr_ca_pkg::AP_BIT]) begin
          next_bank_open[pins.ba] = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_open <= '0;
    end else begin
      bank_open <= next_bank_open;
    end
  end

  // ----------------------------------------------------------------
  // Clock enable and power state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= pins.cke;
    end
  end

  // Self-refresh exit acts on the enable level alone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state <= ddr_ca_pkg::PWR_ACTIVE;
    end else begin
      case (pwr_state)
        ddr_ca_pkg::PWR_ACTIVE: begin
          if (cke_q && !pins.cke) begin
            if (bank_open != '0) begin
              pwr_state <= ddr_ca_pkg::PWR_PDN_ACT;
            end else if ({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n}
                         == ddr_ca_pkg::CMD_REF) begin
              pwr_state <= ddr_ca_pkg::PWR_SELF_REF;
            end else begin
              pwr_state <= ddr_ca_pkg::PWR_PDN_PRE;
            end
          end
        end
        ddr_ca_pkg::PWR_PDN_ACT, ddr_ca_pkg::PWR_PDN_PRE: begin
          if (pins.cke) begin
            pwr_state <= ddr_ca_pkg::PWR_ACTIVE;
          end
        end
        ddr_ca_pkg::PWR_SELF_REF: begin
          if (pins.cke) begin
            pwr_state <= ddr_ca_pkg::PWR_ACTIVE;
          end
        end
        default: pwr_state <= ddr_ca_pkg::PWR_ACTIVE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Termination and write data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      term_on <= 1'b0;
    end else if (!term_allowed || !odt_buf_on) begin
      term_on <= 1'b0;
    end else begin
      term_on <= pins.odt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_beat_valid <= 1'b0;
      wr_beat_data <= '0;
    end else begin
      // Mask is inert while the ball serves as termination strobe
      wr_beat_valid <= pins.dq_wr_valid &&
        (tdqs_on || !pins.dm);
      wr_beat_data <= pins.dq_wr;
    end
  end
endmodule : ddr_ca_dev
`default_nettype wire

// file: test/ddr_ca_properties.sv
// Concurrent checks on the pin interface and device outputs
`timescale 1ns/1ps
`default_nettype none
module ddr_ca_properties (
  // Clock and pins
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr,
  input wire logic odt,
  input wire logic dm,
  input wire logic dq_wr_valid,
  // Device outputs
  input wire logic act_pulse,
  input wire logic rd_pulse,
  input wire logic wr_pulse,
  input wire logic ref_pulse,
  input wire logic pre_pulse,
  input wire logic mrs_pulse,
  input wire logic [2:0] cmd_bank,
  input wire logic [15:0] row_addr,
  input wire logic pre_all,
  input wire logic [15:0] mode_reg [4],
  input wire ddr_ca_pkg::pwr_state_t pwr_state,
  input wire logic term_on,
  input wire logic tdqs_on,
  input wire logic wr_beat_valid
);
  // ----
  // Helpers
  // ----
  logic any_p;
  logic rtt;
  assign any_p = act_pulse | rd_pulse | wr_pulse | pre_pulse | ref_pulse |
    mrs_pulse;
  assign rtt = |{mode_reg[1][ddr_ca_pkg::MR1_RTT_A],
    mode_reg[1][ddr_ca_pkg::MR1_RTT_B], mode_reg[1][ddr_ca_pkg::MR1_RTT_C]};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_cmd(logic [3:0] c);
    {cs_n, ras_n, cas_n, we_n} == c && cke && $past(cke) &&
      pwr_state == ddr_ca_pkg::PWR_ACTIVE;
  endsequence
  // ----
  // Properties
  // ----
  a_act_decode: assert property (
    s_cmd(ddr_ca_pkg::CMD_ACT) |=> act_pulse &&
    row_addr == $past(addr) && cmd_bank == $past(ba))
    else $error("activate decode wrong");
  a_pre_scope: assert property (
    s_cmd(ddr_ca_pkg::CMD_PRE) |=> pre_pulse &&
    pre_all == $past(addr[10]) && cmd_bank == $past(ba))
    else $error("precharge scope wrong");
  a_mrs_load: assert property (
    s_cmd(ddr_ca_pkg::CMD_MRS) |=> mrs_pulse &&
    mode_reg[$past(ba[1:0])] == $past(addr))
    else $error("mode load wrong");
  a_cs_mask: assert property (cs_n |=> !any_p)
    else $error("command passed with chip select high");
  a_cke_gate: assert property (
    !cke || !$past(cke) |=> !any_p)
    else $error("command passed with clock enable low");
  a_mask_drop: assert property (
    dq_wr_valid && dm && !tdqs_on |=> !wr_beat_valid)
    else $error("masked beat accepted");
  a_term_ctrl: assert property (
    cke && pwr_state != ddr_ca_pkg::PWR_SELF_REF |=>
    term_on == ($past(odt) && $past(rtt)))
    else $error("termination state wrong");
  a_reset_idle: assert property (disable iff (1'b0)
    !reset_n |-> pwr_state == ddr_ca_pkg::PWR_ACTIVE && !term_on && !any_p)
    else $error("state not cleared in reset");
endmodule : ddr_ca_properties
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench joining controller and device ends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----
  // Signals
  // ----
  logic ref_clk = 1'b0, rst_n = 1'b1, req_valid = 1'b0, req_cke = 1'b1;
  logic req_odt = 1'b0, mem_reset_n = 1'b1, wr_valid = 1'b0, wr_mask = 1'b0;
  logic [3:0] req_cmd = 4'h8, c;
  logic [2:0] req_bank = 3'h0, b;
  logic [15:0] req_addr = 16'h0000, a, mr [4];
  logic [7:0] wr_data = 8'h00;
  logic act_pulse, rd_pulse, wr_pulse, pre_pulse, ref_pulse, mrs_pulse;
  logic auto_pre, pre_all, burst_four, term_on, tdqs_on, wr_beat_valid;
  logic [2:0] cmd_bank;
  logic [15:0] row_addr, mode_reg [4];
  logic [9:0] col_addr;
  logic [7:0] bank_open, wr_beat_data;
  logic [4:0] pulses;
  ddr_ca_pkg::pwr_state_t pwr_state;
  logic [3:0] cmds [6] = '{ddr_ca_pkg::CMD_ACT, ddr_ca_pkg::CMD_RD,
    ddr_ca_pkg::CMD_WR, ddr_ca_pkg::CMD_PRE, ddr_ca_pkg::CMD_DES,
    ddr_ca_pkg::CMD_MRS};
  int errors = 0, compares = 0, cycles = 0, k;
  always #12.5 ref_clk = ~ref_clk;
  ddr_ca_if bus();
  ddr_ca_ctrl i_ddr_ca_ctrl (.ref_clk, .rst_n, .req_valid, .req_ready(),
    .req_cmd, .req_bank, .req_addr, .req_cke, .req_odt, .mem_reset_n,
    .wr_valid, .wr_data, .wr_mask, .pins(bus));
  ddr_ca_dev i_ddr_ca_dev (.ref_clk, .pins(bus), .act_pulse, .rd_pulse,
    .wr_pulse, .pre_pulse, .ref_pulse, .mrs_pulse, .cmd_bank, .row_addr,
    .col_addr, .auto_pre, .pre_all, .burst_four, .mode_reg, .pwr_state,
    .term_on, .tdqs_on, .bank_open, .wr_beat_valid, .wr_beat_data);
  ddr_ca_properties i_ddr_ca_properties (.ref_clk, .reset_n(bus.reset_n),
    .cke(bus.cke), .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n),
    .we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr), .odt(bus.odt),
    .dm(bus.dm), .dq_wr_valid(bus.dq_wr_valid), .act_pulse, .pre_pulse,
    .mrs_pulse, .cmd_bank, .row_addr, .pre_all, .mode_reg, .pwr_state,
    .term_on, .tdqs_on, .wr_beat_valid, .rd_pulse, .wr_pulse, .ref_pulse);
  assign pulses = {act_pulse, rd_pulse, wr_pulse, pre_pulse, mrs_pulse};
  // ----
  // Tasks
  // ----
  task automatic check(input string n, input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check
  function automatic logic [4:0] exp_pulse(input logic [3:0] x);
    return {x == cmds[0], x == cmds[1], x == cmds[2], x == cmds[3],
      x == cmds[5]};
  endfunction : exp_pulse
  function automatic logic [11:0] exp_col(input logic [15:0] x);
    return {mr[0][1:0] == ddr_ca_pkg::BL_OTF && !x[ddr_ca_pkg::BC_BIT],
      x[ddr_ca_pkg::AP_BIT], x[9:0]};
  endfunction : exp_col
  task automatic beat(input logic m, input logic [7:0] d);
    @(posedge ref_clk);
    wr_valid <= 1'b1;
    wr_mask <= m;
    wr_data <= d;
    @(posedge ref_clk);
    wr_valid <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : beat
  task automatic send(input logic [3:0] x, input logic [2:0] y,
    input logic [15:0] z);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_cmd <= x;
    req_bank <= y;
    req_addr <= z;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    check("pins", {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n},
      x);
    @(posedge ref_clk);
    #1;
  endtask : send
  task automatic set_cke(input logic v, input ddr_ca_pkg::pwr_state_t e);
    @(posedge ref_clk);
    req_cke <= v;
    repeat (3) @(posedge ref_clk);
    #1;
    check("pwr", pwr_state, e);
  endtask : set_cke
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    k = $urandom(91296);
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      mr[i] = (i == 1) ? 16'h0004 : 16'($urandom());
      send(ddr_ca_pkg::CMD_MRS, 3'(i), mr[i]);
      check("mode_reg", mode_reg[i], mr[i]);
    end
    for (int n = 0; n < 60; n++) begin
      c = cmds[$urandom_range(5)];
      b = (c == ddr_ca_pkg::CMD_MRS) ? 3'h0 : 3'($urandom());
      a = (n < 2) ? {16{n[0]}} : 16'($urandom());
      if (c == ddr_ca_pkg::CMD_MRS)
        mr[0] = a;
      send(c, b, a);
      check("pulses", pulses, exp_pulse(c));
      if (c == cmds[0])
        check("row", {row_addr[12:0], cmd_bank},
          {a[12:0], b});
      if (c == cmds[1] || c == cmds[2])
        check("col", {burst_four, auto_pre, col_addr},
          exp_col(a));
      if (c == cmds[3])
        check("pre", {pre_all, cmd_bank}, {a[10], b});
    end
    for (int n = 0; n < 8; n++) begin
      beat(n[0], 8'($urandom()));
      check("beat", {wr_beat_valid, wr_beat_data},
        {!n[0], wr_data});
    end
    @(posedge ref_clk);
    req_odt <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check("term", term_on, 1'b1);
    send(ddr_ca_pkg::CMD_MRS, 3'h1, 16'h0000);
    @(posedge ref_clk);
    #1;
    check("term", term_on, 1'b0);
    send(ddr_ca_pkg::CMD_MRS, 3'h1, 16'h0800);
    check("tdqs", tdqs_on, 1'b1);
    beat(1'b1, 8'h5a);
    check("tdqs_beat", wr_beat_valid, 1'b1);
    send(ddr_ca_pkg::CMD_PRE, 3'h0, 16'h0400);
    check("open", bank_open, 8'h00);
    send(ddr_ca_pkg::CMD_ACT, 3'h2, 16'h0123);
    check("open", bank_open, 8'h04);
    set_cke(1'b0, ddr_ca_pkg::PWR_PDN_ACT);
    send(ddr_ca_pkg::CMD_PRE, 3'h0, 16'h0400);
    check("masked", pre_pulse, 1'b0);
    set_cke(1'b1, ddr_ca_pkg::PWR_ACTIVE);
    send(ddr_ca_pkg::CMD_PRE, 3'h0, 16'h0400);
    set_cke(1'b0, ddr_ca_pkg::PWR_PDN_PRE);
    set_cke(1'b1, ddr_ca_pkg::PWR_ACTIVE);
    send(ddr_ca_pkg::CMD_REF, 3'h0, 16'h0000);
    check("refresh", ref_pulse, 1'b1);
    @(posedge ref_clk);
    req_cmd <= ddr_ca_pkg::CMD_REF;
    req_valid <= 1'b1;
    req_cke <= 1'b0;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    set_cke(1'b0, ddr_ca_pkg::PWR_SELF_REF);
    set_cke(1'b1, ddr_ca_pkg::PWR_ACTIVE);
    @(posedge ref_clk);
    mem_reset_n <= 1'b0;
    #1;
    check("reset", mode_reg[0], 16'h0000);
    mem_reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    send(ddr_ca_pkg::CMD_ACT, 3'h5, 16'h00ff);
    check("row", {act_pulse, cmd_bank}, 4'hd);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
